/* File: serial_int_ack_n_defines.svh */
// Timing counts and reset values for the acknowledge sequencer and its link
`ifndef SERIAL_INT_ACK_N_DEFINES_SVH
`define SERIAL_INT_ACK_N_DEFINES_SVH

`define CLK_PERIOD_NS       40
`define AUTO_WAIT_STATES    2
`define ADDED_WAIT_STATES   3
`define TOTAL_WAIT_STATES   5
`define RX_REQ_MIN_CYC      4'h8
`define RX_REQ_MAX_CYC      4'hC
`define TX_REQ_MIN_CYC      4'h5
`define TX_REQ_MAX_CYC      4'h8
`define MODEM_INT_MIN_CYC   4'h2
`define MODEM_INT_MAX_CYC   4'h6
`define RECOVERY_CYC        4'h4
`define CHAIN_PROP_CYC      2'h1
`define STROBE_IDLE         1'h1

`endif

/* File: serial_int_ack_n_pkg.sv */
// Types shared by both ends of the acknowledge link
package serial_int_ack_n_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TWA1,
        ST_TWA2,
        ST_TW3,
        ST_TW4,
        ST_TW5,
        ST_T3
    } ack_state_t;

endpackage

/* File: serial_int_ack_n_link_if.sv */
// Link between the sequencer and the external chained peripheral and bus master
`timescale 1ns/1ps
interface serial_int_ack_n_link_if (
    input wire logic clk,
    input wire logic rst_b
);
    logic io_request_n;
    logic opcode_fetch_cycle_n;
    logic priority_in;
    logic wait_request_n;
    logic int_request_n;
    logic ext_access_n;

    modport device (
        input  clk,
        input  rst_b,
        output io_request_n,
        output opcode_fetch_cycle_n,
        input  priority_in,
        output wait_request_n,
        output int_request_n,
        input  ext_access_n
    );

    modport other (
        input  clk,
        input  rst_b,
        input  io_request_n,
        input  opcode_fetch_cycle_n,
        output priority_in,
        input  wait_request_n,
        input  int_request_n,
        output ext_access_n
    );
endinterface

/* File: serial_int_ack_n_daisy_chain_sequencer.sv */
// Interrupt acknowledge sequencer, internal strobes and event latency timers
//
// Summary of operation
// - Acknowledge cycle carries five wait states total
// - Serial acknowledge strobe asserted at T1
// - Serial read strobe asserted at fourth wait
// - Timer I/O request asserted with serial read
// - External I/O request asserted at first auto wait
// - External chained peripherals sit at higher priority
// - External priority propagation under two clocks
// - Lower-priority external peripheral needs delayed request
// - Four clocks recovery between serial controller accesses
// - Receive clock to request within 8..12 clocks
// - Transmit clock to request within 5..8 clocks
// - Modem change to interrupt within 2..6 clocks
`timescale 1ns/1ps
`include "serial_int_ack_n_defines.svh"
module serial_int_ack_n_daisy_chain_sequencer (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_b,
    // Link
    serial_int_ack_n_link_if.device link,
    // Core side
    input  wire logic  serial_int_ack_n_start,
    output logic       core_wait,
    output logic       own_vector_claim,
    input  wire logic  own_int_pending,
    // Internal strobes
    output logic       serial_int_ack_n,
    output logic       serial_read_n,
    output logic       counter_timer_io_request_n,
    // Serial controller events
    input  wire logic  receive_clock,
    input  wire logic  transmit_clock,
    input  wire logic  rx_request,
    input  wire logic  tx_request,
    input  wire logic  carrier_detect_n,
    input  wire logic  clear_to_send_n,
    input  wire logic  modem_int_clear,
    // Bus master access watch
    output logic       recovery_violation
);
    import serial_int_ack_n_pkg::*;

    ack_state_t state;
    ack_state_t next_state;
    logic       rx_prev;
    logic       tx_prev;
    logic       dcd_prev;
    logic       cts_prev;
    logic [3:0] rx_cnt;
    logic [3:0] tx_cnt;
    logic [3:0] modem_cnt;
    logic       rx_held;
    logic       tx_held;
    logic [3:0] access_gap;
    logic       access_prev_n;
    logic       rx_edge;
    logic       tx_edge;
    logic       modem_edge;

    // Bus state walk; the added waits cover serial and timer settle time
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (serial_int_ack_n_start) next_state = ST_T1;
            ST_T1:   next_state = ST_T2;
            ST_T2:   next_state = ST_TWA1;
            ST_TWA1: next_state = ST_TWA2;
            ST_TWA2: next_state = ST_TW3;
            ST_TW3:  next_state = ST_TW4;
            ST_TW4:  next_state = ST_TW5;
            ST_TW5:  next_state = ST_T3;
            ST_T3:   next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Strobes follow next state so that each output stays a plain flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.opcode_fetch_cycle_n  <= `STROBE_IDLE;
            serial_int_ack_n           <= `STROBE_IDLE;
            link.io_request_n          <= `STROBE_IDLE;
            serial_read_n              <= `STROBE_IDLE;
            counter_timer_io_request_n <= `STROBE_IDLE;
            core_wait                  <= 1'h0;
        end else begin
            link.opcode_fetch_cycle_n  <= (next_state == ST_IDLE);
            serial_int_ack_n           <= (next_state == ST_IDLE);
            link.io_request_n          <= !(next_state inside {ST_TWA1, ST_TWA2, ST_TW3,
                                                               ST_TW4, ST_TW5, ST_T3});
            serial_read_n              <= !(next_state inside {ST_TW4, ST_TW5, ST_T3});
            counter_timer_io_request_n <= !(next_state inside {ST_TW4, ST_TW5, ST_T3});
            core_wait                  <= (next_state inside {ST_TW3, ST_TW4, ST_TW5});
        end
    end

    // Chain settles by fourth wait; external parts ahead of us gate priority_in
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            own_vector_claim <= 1'h0;
        end else if (next_state == ST_TW4) begin
            own_vector_claim <= link.priority_in && own_int_pending;
        end else if (next_state == ST_IDLE) begin
            own_vector_claim <= 1'h0;
        end
    end

    // Edge history of the event inputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_prev  <= 1'h0;
            tx_prev  <= 1'h0;
            dcd_prev <= 1'h1;
            cts_prev <= 1'h1;
        end else begin
            rx_prev  <= receive_clock;
            tx_prev  <= transmit_clock;
            dcd_prev <= carrier_detect_n;
            cts_prev <= clear_to_send_n;
        end
    end

    assign rx_edge    = receive_clock != rx_prev;
    assign tx_edge    = transmit_clock != tx_prev;
    assign modem_edge = (carrier_detect_n != dcd_prev) || (clear_to_send_n != cts_prev);

    // Receive latency timer; a new edge restarts it, so rapid edges only delay
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt  <= 4'h0;
            rx_held <= 1'h0;
        end else if (rx_edge) begin
            rx_cnt  <= `RX_REQ_MIN_CYC;
            rx_held <= rx_request;
        end else if (rx_cnt != 4'h0) begin
            rx_cnt <= rx_cnt - 4'h1;
        end
    end

    // Transmit latency timer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt  <= 4'h0;
            tx_held <= 1'h0;
        end else if (tx_edge) begin
            tx_cnt  <= `TX_REQ_MIN_CYC;
            tx_held <= tx_request;
        end else if (tx_cnt != 4'h0) begin
            tx_cnt <= tx_cnt - 4'h1;
        end
    end

    // Shared request pin takes whichever timer expires; receive wins a tie
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.wait_request_n <= 1'h1;
        end else if (!rx_edge && rx_cnt == 4'h1) begin
            link.wait_request_n <= !rx_held;
        end else if (!tx_edge && tx_cnt == 4'h1) begin
            link.wait_request_n <= !tx_held;
        end
    end

    // Modem interrupt; a pending set beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modem_cnt <= 4'h0;
        end else if (modem_edge) begin
            modem_cnt <= `MODEM_INT_MIN_CYC;
        end else if (modem_cnt != 4'h0) begin
            modem_cnt <= modem_cnt - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.int_request_n <= 1'h1;
        end else if (!modem_edge && modem_cnt == 4'h1) begin
            link.int_request_n <= 1'h0;
        end else if (modem_int_clear) begin
            link.int_request_n <= 1'h1;
        end
    end

    // Flags an external master that starts a serial access too soon
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            access_prev_n      <= 1'h1;
            access_gap         <= `RECOVERY_CYC;
            recovery_violation <= 1'h0;
        end else begin
            access_prev_n <= link.ext_access_n;
            if (!link.ext_access_n) begin
                access_gap <= 4'h0;
            end else if (access_gap != `RECOVERY_CYC) begin
                access_gap <= access_gap + 4'h1;
            end
            if (!link.ext_access_n && access_prev_n && access_gap != `RECOVERY_CYC) begin
                recovery_violation <= 1'h1;
            end
        end
    end

endmodule

/* File: serial_int_ack_n_chain_peer.sv */
// External chained peripheral and external bus master facing the sequencer
`timescale 1ns/1ps
`include "serial_int_ack_n_defines.svh"
module serial_int_ack_n_chain_peer #(
    parameter int          PLACE_LOW     = 0,
    parameter logic [3:0]  REQ_DELAY_CYC = 4'h6
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_b,
    // Link
    serial_int_ack_n_link_if.other link,
    // Peripheral side
    input  wire logic  chain_top_in,
    input  wire logic  peer_int_pending,
    output logic       peer_vector_claim,
    // Bus master side
    input  wire logic  access_req,
    output logic       access_busy
);
    import serial_int_ack_n_pkg::*;

    logic       io_req_seen_n;
    logic [3:0] req_dly;
    logic [3:0] gap;
    logic       prio_out;

    // One-flop propagation stays under two clocks; we sit at the chain head
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prio_out <= 1'h1;
        end else begin
            prio_out <= chain_top_in && !(peer_int_pending || peer_vector_claim);
        end
    end

    assign link.priority_in = prio_out;

    // Low placement delays the acknowledge request seen by this part
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_dly <= 4'h0;
        end else if (link.io_request_n) begin
            req_dly <= 4'h0;
        end else if (req_dly != REQ_DELAY_CYC) begin
            req_dly <= req_dly + 4'h1;
        end
    end

    assign io_req_seen_n = (PLACE_LOW != 0) ? (link.io_request_n || req_dly != REQ_DELAY_CYC)
                                            : link.io_request_n;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            peer_vector_claim <= 1'h0;
        end else if (link.opcode_fetch_cycle_n) begin
            peer_vector_claim <= 1'h0;
        end else if (!io_req_seen_n && chain_top_in && peer_int_pending) begin
            peer_vector_claim <= 1'h1;
        end
    end

    // Bus master: one-cycle access then enforced recovery gap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.ext_access_n <= 1'h1;
            gap               <= `RECOVERY_CYC;
        end else if (access_req && gap == `RECOVERY_CYC && link.ext_access_n) begin
            link.ext_access_n <= 1'h0;
            gap               <= 4'h0;
        end else begin
            link.ext_access_n <= 1'h1;
            if (gap != `RECOVERY_CYC) begin
                gap <= gap + 4'h1;
            end
        end
    end

    assign access_busy = !link.ext_access_n || gap != `RECOVERY_CYC;

endmodule

/* File: serial_int_ack_n_link_sva.sv */
// Protocol checks on the acknowledge link
`timescale 1ns/1ps
module serial_int_ack_n_link_sva (
    // Link signals
    input wire logic clk,
    input wire logic rst_b,
    input wire logic io_request_n,
    input wire logic opcode_fetch_cycle_n,
    input wire logic priority_in,
    input wire logic wait_request_n,
    input wire logic int_request_n,
    input wire logic ext_access_n,
    // Event inputs behind the request pins
    input wire logic receive_clock,
    input wire logic rx_request,
    input wire logic carrier_detect_n,
    input wire logic clear_to_send_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence ack_begin;
        $fell(opcode_fetch_cycle_n);
    endsequence
    sequence io_begin;
        $fell(io_request_n);
    endsequence
    sequence rx_settled;
        $changed(receive_clock) ##1 (!$changed(receive_clock)) [*8];
    endsequence
    sequence modem_settled;
        ($changed(carrier_detect_n) || $changed(clear_to_send_n))
            ##1 (!($changed(carrier_detect_n) || $changed(clear_to_send_n))) [*2];
    endsequence
    AST_ACK_LEN: assert property (ack_begin |-> !opcode_fetch_cycle_n [*8] ##1 opcode_fetch_cycle_n)
        else $error("ack cycle length wrong");
    AST_IO_AT_WAIT: assert property (ack_begin |-> io_request_n [*2] ##1 !io_request_n)
        else $error("io request late or early");
    AST_IO_LEN: assert property (io_begin |-> !io_request_n [*6] ##1 io_request_n)
        else $error("io request length wrong");
    AST_IO_INSIDE: assert property (!io_request_n |-> !opcode_fetch_cycle_n)
        else $error("io request outside ack");
    AST_RELEASE: assert property ($rose(opcode_fetch_cycle_n) |-> io_request_n)
        else $error("io request not released");
    AST_PRIO_SETTLE: assert property (io_begin |=> $stable(priority_in) [*3])
        else $error("priority moved late");
    AST_ACCESS_ONE: assert property ($fell(ext_access_n) |=> $rose(ext_access_n))
        else $error("access pulse too long");
    AST_ACCESS_GAP: assert property ($rose(ext_access_n) |-> ext_access_n [*4])
        else $error("access recovery too short");
    AST_RX_REQ: assert property (rx_settled |=> wait_request_n == !$past(rx_request, 9))
        else $error("receive request wrong or late");
    AST_MODEM_INT: assert property (modem_settled |=> !int_request_n)
        else $error("modem interrupt late");
endmodule

/* File: tb_serial_int_ack_n_daisy_chain_sequencer.sv */
// Self-checking bench for the sequencer facing its chained peer
`timescale 1ns/1ps
`include "serial_int_ack_n_defines.svh"
module tb_serial_int_ack_n_daisy_chain_sequencer;
    logic        clk, rst_b, serial_int_ack_n_start, core_wait, own_vector_claim, own_int_pending, serial_int_ack_n;
    logic        serial_read_n, counter_timer_io_request_n, receive_clock, transmit_clock, rx_request;
    logic        tx_request, carrier_detect_n, clear_to_send_n, modem_int_clear, recovery_violation;
    logic        chain_top_in, peer_int_pending, peer_vector_claim, access_req, access_busy;
    logic        pa, pw, pi, fo, wexp;
    logic [3:0]  rd_at, ct_at, io_at, nw;
    logic [1:0]  cl;
    logic [23:0] expq[$];
    int          n_tests, n_mismatch, cyc, t, t_drive;

    serial_int_ack_n_link_if serial_int_ack_n_link_if_i (.clk(clk), .rst_b(rst_b));
    serial_int_ack_n_daisy_chain_sequencer serial_int_ack_n_daisy_chain_sequencer_i (.clk(clk), .rst_b(rst_b),
        .link(serial_int_ack_n_link_if_i), .serial_int_ack_n_start(serial_int_ack_n_start), .core_wait(core_wait),
        .own_vector_claim(own_vector_claim), .own_int_pending(own_int_pending),
        .serial_int_ack_n(serial_int_ack_n), .serial_read_n(serial_read_n),
        .counter_timer_io_request_n(counter_timer_io_request_n), .receive_clock(receive_clock),
        .transmit_clock(transmit_clock), .rx_request(rx_request), .tx_request(tx_request),
        .carrier_detect_n(carrier_detect_n), .clear_to_send_n(clear_to_send_n),
        .modem_int_clear(modem_int_clear), .recovery_violation(recovery_violation));
    serial_int_ack_n_chain_peer serial_int_ack_n_chain_peer_i (.clk(clk), .rst_b(rst_b), .link(serial_int_ack_n_link_if_i),
        .chain_top_in(chain_top_in), .peer_int_pending(peer_int_pending),
        .peer_vector_claim(peer_vector_claim), .access_req(access_req), .access_busy(access_busy));
    serial_int_ack_n_link_sva serial_int_ack_n_link_sva_i (.clk(clk), .rst_b(rst_b), .io_request_n(serial_int_ack_n_link_if_i.io_request_n),
        .opcode_fetch_cycle_n(serial_int_ack_n_link_if_i.opcode_fetch_cycle_n), .priority_in(serial_int_ack_n_link_if_i.priority_in),
        .wait_request_n(serial_int_ack_n_link_if_i.wait_request_n), .int_request_n(serial_int_ack_n_link_if_i.int_request_n),
        .ext_access_n(serial_int_ack_n_link_if_i.ext_access_n), .receive_clock(receive_clock), .rx_request(rx_request),
        .carrier_detect_n(carrier_detect_n), .clear_to_send_n(clear_to_send_n));

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [23:0] pop();
        if (expq.size() == 0) return 24'hFFFFFF;
        return expq.pop_front();
    endfunction

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Config bits: chain top, peer pending, own pending; gap 0 gives back-to-back cycles
    task automatic ack(input logic [2:0] cfg, input int gap);
        @(posedge clk);
        {chain_top_in, peer_int_pending, own_int_pending} <= cfg;
        repeat (gap) @(posedge clk);
        expq.push_back({4'h1, 4'h5, 4'h5, 4'h2, 4'h3, cfg[2] & ~cfg[1] & cfg[0], cfg[2] & cfg[1], 2'h0});
        serial_int_ack_n_start <= 1'b1;
        @(posedge clk);
        serial_int_ack_n_start <= 1'b0;
        repeat (7) @(posedge clk);
    endtask

    // Request level is chosen so every event really moves the output
    task automatic ser(input int k);
        @(posedge clk);
        t_drive = cyc;
        if (k == 0) begin
            rx_request <= wexp;
            receive_clock <= !receive_clock;
            // Pin is seen one edge after it is driven, so one more than the timer count
            expq.push_back({4'h2, 8'(`RX_REQ_MIN_CYC + 4'h1), 11'h000, !wexp});
            if ($urandom % 2) begin
                repeat (3) @(posedge clk);
                t_drive = cyc;
                receive_clock <= !receive_clock;
            end
            wexp = !wexp;
        end else if (k == 1) begin
            tx_request <= wexp;
            transmit_clock <= !transmit_clock;
            expq.push_back({4'h2, 8'(`TX_REQ_MIN_CYC + 4'h1), 11'h000, !wexp});
            wexp = !wexp;
        end else begin
            if ($urandom % 2) carrier_detect_n <= !carrier_detect_n;
            else clear_to_send_n <= !clear_to_send_n;
            expq.push_back({4'h3, 8'(`MODEM_INT_MIN_CYC + 4'h1), 12'h000});
            repeat (4) @(posedge clk);
            t_drive = cyc;
            modem_int_clear <= 1'b1;
            expq.push_back({4'h3, 8'h01, 12'h001});
            @(posedge clk);
            modem_int_clear <= 1'b0;
        end
        repeat (12) @(posedge clk);
    endtask

    always @(negedge clk) begin
        if (rst_b) begin
            if (!serial_int_ack_n) begin
                if (pa) begin
                    t = 0;
                    {rd_at, ct_at, io_at, nw, cl} = '0;
                    fo = serial_int_ack_n_link_if_i.opcode_fetch_cycle_n;
                end
                if (!serial_read_n && rd_at == 4'h0) rd_at = 4'(t);
                if (!counter_timer_io_request_n && ct_at == 4'h0) ct_at = 4'(t);
                if (!serial_int_ack_n_link_if_i.io_request_n && io_at == 4'h0) io_at = 4'(t);
                nw = nw + 4'(core_wait);
                cl = cl | {own_vector_claim, peer_vector_claim};
                t++;
            end else if (!pa) begin
                chk({4'h1, rd_at, ct_at, io_at, nw, cl, 1'b0, fo}, pop());
            end
            if (serial_int_ack_n_link_if_i.wait_request_n !== pw)
                chk({4'h2, 8'(cyc - t_drive), 11'h000, serial_int_ack_n_link_if_i.wait_request_n}, pop());
            if (serial_int_ack_n_link_if_i.int_request_n !== pi)
                chk({4'h3, 8'(cyc - t_drive), 11'h000, serial_int_ack_n_link_if_i.int_request_n}, pop());
        end
        pa = serial_int_ack_n;
        pw = serial_int_ack_n_link_if_i.wait_request_n;
        pi = serial_int_ack_n_link_if_i.int_request_n;
        cyc++;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst_b = 1'b0;
        wexp = 1'b1;
        {serial_int_ack_n_start, own_int_pending, chain_top_in, peer_int_pending, access_req, modem_int_clear} = 6'h00;
        {receive_clock, transmit_clock, rx_request, tx_request} = 4'h0;
        {carrier_detect_n, clear_to_send_n} = 2'h3;
        void'($urandom(94));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            ack(3'(i), 2);
            ack(3'(i), 0);
        end
        $display("ack tests done");
        for (int i = 0; i < 12; i++) ser($urandom % 3);
        $display("serial tests done");
        @(posedge clk);
        access_req <= 1'b1;
        repeat (2) @(negedge clk);
        chk({23'h000000, access_busy}, 24'h000001);
        repeat (29) @(posedge clk);
        access_req <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({23'h000000, access_busy}, 24'h000000);
        chk({23'h000000, recovery_violation}, 24'h000000);
        chk(24'(expq.size()), 24'h000000);
        $display("access tests done");
        finish_test();
    end
endmodule
